//--- src/qct_pkg.sv
`default_nettype none
package qct_pkg;
    localparam int          QCT_CNT_W      = 16;
    localparam int          QCT_NUM_CH     = 4;
    localparam int          QCT_PRESC_W    = 7;
    localparam int          QCT_ADDR_W     = 8;
    localparam logic [7:0]  QCT_OFF_TSC    = 8'h00;
    localparam logic [7:0]  QCT_OFF_MOD    = 8'h04;
    localparam logic [7:0]  QCT_OFF_CNT    = 8'h08;
    localparam logic [7:0]  QCT_OFF_CH     = 8'h10;
    localparam logic [7:0]  QCT_CH_STRIDE  = 8'h08;
    localparam logic [7:0]  QCT_OFF_VAL    = 8'h04;
    localparam int          QCT_TSC_PS_LSB = 0;
    localparam int          QCT_TSC_STOP   = 4;
    localparam int          QCT_TSC_RST    = 5;
    localparam int          QCT_TSC_OVIE   = 6;
    localparam int          QCT_TSC_OVF    = 7;
    localparam int          QCT_TSC_MODEN  = 8;
    localparam int          QCT_CSC_FLAG   = 6;
    localparam logic [2:0]  QCT_PS_EXT     = 3'h7;
    localparam logic [2:0]  QCT_PS_RST     = 3'h0;
    localparam logic [15:0] QCT_MOD_RST    = 16'hFFFF;
    localparam logic [1:0]  QCT_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  QCT_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        QCT_ELS_OFF    = 2'h0,
        QCT_ELS_RISE   = 2'h1,
        QCT_ELS_FALL   = 2'h2,
        QCT_ELS_EITHER = 2'h3
    } qct_edge_e;
    typedef enum logic [1:0] {
        QCT_ACT_NONE   = 2'h0,
        QCT_ACT_TOGGLE = 2'h1,
        QCT_ACT_CLEAR  = 2'h2,
        QCT_ACT_SET    = 2'h3
    } qct_action_e;
    typedef struct packed {
        logic       irq_en;
        logic       tov;
        logic       ms_b;
        logic       ms_a;
        logic [1:0] els;
    } qct_chan_ctrl_s;
    localparam qct_chan_ctrl_s QCT_CTRL_RST = 6'h00;
endpackage : qct_pkg
`default_nettype wire

//--- src/qct_timer.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module qct_timer
    import qct_pkg::*;
#(
    parameter int unsigned CNT_W = QCT_CNT_W
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [QCT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [QCT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  external_clock_pin,
    input  wire logic [3:0]            chan_pin_in,
    output logic [3:0]                 chan_pin_out,
    output logic [3:0]                 chan_pin_oe,
    output logic                       overflow_irq,
    output logic [3:0]                 channel_irq
);
    if (CNT_W < 2 || CNT_W > QCT_CNT_W)
    begin : g_bad_cnt_w
        $error("CNT_W must lie between 2 and 16");
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [QCT_ADDR_W-1:0]  aw_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   aw_have_reg;
    logic                   w_have_reg;
    logic                   wr_en;
    logic [31:0]            wr_mask;
    logic                   rd_take;
    logic [31:0]            rd_data;
    logic                   rd_ok;
    logic [2:0]             presc_sel_reg;
    logic                   stop_reg;
    logic                   ovie_reg;
    logic                   overflow_flag_reg;
    logic                   moden_reg;
    logic [CNT_W-1:0]       mod_reg;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       cnt_next;
    logic [CNT_W-1:0]       limit;
    logic [QCT_PRESC_W-1:0] presc_cnt_reg;
    logic [QCT_PRESC_W-1:0] presc_mask;
    logic                   ext_prev_reg;
    logic                   tick;
    logic                   ovf_evt;
    logic                   cnt_clr;
    qct_chan_ctrl_s         ctrl_reg [QCT_NUM_CH];
    logic [CNT_W-1:0]       val_reg  [QCT_NUM_CH];
    logic [3:0]             chflag_reg;
    logic [3:0]             pin_prev_reg;
    logic [3:0]             pin_out_reg;
    logic [3:0]             cap_evt;
    logic [3:0]             cmp_evt;
    logic [3:0]             is_oc;
    logic [1:0]             active_odd_reg;
    logic [1:0]             last_odd_reg;

    function automatic logic [QCT_ADDR_W-1:0] ch_off(input int ch, input logic [7:0] sub);
        ch_off = QCT_OFF_CH + QCT_CH_STRIDE * ch[7:0] + sub;
    endfunction : ch_off

    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
    assign wr_en         = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_mask       = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                            {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            aw_addr_reg  <= '0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= QCT_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_en)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map(aw_addr_reg) ? QCT_RESP_OKAY : QCT_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic wr_map(input logic [QCT_ADDR_W-1:0] a);
        wr_map = (a == QCT_OFF_TSC) || (a == QCT_OFF_MOD) || (a == QCT_OFF_CNT);
        for (int c = 0; c < QCT_NUM_CH; c++)
            wr_map = wr_map || (a == ch_off(c, 8'h00)) || (a == ch_off(c, QCT_OFF_VAL));
    endfunction : wr_map

    // AXI4-Lite read: one cycle to answer
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take       = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            QCT_OFF_TSC:
            begin
                rd_data[QCT_TSC_PS_LSB +: 3] = presc_sel_reg;
                rd_data[QCT_TSC_STOP]        = stop_reg;
                rd_data[QCT_TSC_OVIE]        = ovie_reg;
                rd_data[QCT_TSC_OVF]         = overflow_flag_reg;
                rd_data[QCT_TSC_MODEN]       = moden_reg;
            end
            QCT_OFF_MOD: rd_data[CNT_W-1:0] = mod_reg;
            QCT_OFF_CNT: rd_data[CNT_W-1:0] = cnt_reg;
            default:     rd_ok = 1'b0;
        endcase
        for (int c = 0; c < QCT_NUM_CH; c++)
        begin
            if (s_axi_araddr == ch_off(c, 8'h00))
            begin
                rd_ok             = 1'b1;
                rd_data[5:0]      = ctrl_reg[c];
                rd_data[QCT_CSC_FLAG] = chflag_reg[c];
            end
            if (s_axi_araddr == ch_off(c, QCT_OFF_VAL))
            begin
                rd_ok              = 1'b1;
                rd_data[CNT_W-1:0] = val_reg[c];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= QCT_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? QCT_RESP_OKAY : QCT_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Timer status and control
    assign cnt_clr = wr_en && aw_addr_reg == QCT_OFF_TSC && w_strb_reg[0]
                     && w_data_reg[QCT_TSC_RST];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_sel_reg     <= QCT_PS_RST;
            stop_reg          <= 1'b0;
            ovie_reg          <= 1'b0;
            moden_reg         <= 1'b0;
            overflow_flag_reg <= 1'b0;
            mod_reg           <= QCT_MOD_RST[CNT_W-1:0];
        end
        else
        begin
            if (wr_en && aw_addr_reg == QCT_OFF_TSC && w_strb_reg[0])
            begin
                presc_sel_reg <= w_data_reg[QCT_TSC_PS_LSB +: 3];
                stop_reg      <= w_data_reg[QCT_TSC_STOP];
                ovie_reg      <= w_data_reg[QCT_TSC_OVIE];
            end
            if (wr_en && aw_addr_reg == QCT_OFF_TSC && w_strb_reg[1])
                moden_reg <= w_data_reg[QCT_TSC_MODEN];
            if (ovf_evt)
                overflow_flag_reg <= 1'b1;
            else if (wr_en && aw_addr_reg == QCT_OFF_TSC && w_strb_reg[0]
                     && w_data_reg[QCT_TSC_OVF])
                overflow_flag_reg <= 1'b0;
            if (wr_en && aw_addr_reg == QCT_OFF_MOD)
                mod_reg <= ((mod_reg & wr_mask[CNT_W-1:0])
                            | (mod_reg & ~wr_mask[CNT_W-1:0])) == mod_reg
                           ? (w_data_reg[CNT_W-1:0] & wr_mask[CNT_W-1:0])
                             | (mod_reg & ~wr_mask[CNT_W-1:0])
                           : mod_reg;
        end
    end

    // Prescaler and counter
    assign presc_mask = QCT_PRESC_W'((8'h01 << presc_sel_reg) - 8'h01);
    assign tick       = !stop_reg && (presc_sel_reg == QCT_PS_EXT
                        ? (external_clock_pin && !ext_prev_reg)
                        : ((presc_cnt_reg & presc_mask) == presc_mask));
    assign limit      = moden_reg ? mod_reg : {CNT_W{1'b1}};
    assign cnt_next   = (cnt_reg == limit) ? '0 : cnt_reg + 1'b1;
    // Overflow at the wrap, so pulse width equals channel value
    assign ovf_evt    = tick && !cnt_clr && cnt_reg == limit;
    assign overflow_irq = overflow_flag_reg && ovie_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_cnt_reg <= '0;
            cnt_reg       <= '0;
            ext_prev_reg  <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= external_clock_pin;
            if (cnt_clr)
            begin
                presc_cnt_reg <= '0;
                cnt_reg       <= '0;
            end
            else
            begin
                if (!stop_reg)
                    presc_cnt_reg <= presc_cnt_reg + 1'b1;
                if (tick)
                    cnt_reg <= cnt_next;
            end
        end
    end

    // Buffered pairs 0/1 and 2/3
    for (genvar p = 0; p < 2; p++)
    begin : g_pair
        always_ff @(posedge aclk)
        begin
            if (!aresetn || !ctrl_reg[2*p].ms_b)
            begin
                active_odd_reg[p] <= 1'b0;
                last_odd_reg[p]   <= 1'b0;
            end
            else
            begin
                if (wr_en && aw_addr_reg == ch_off(2*p+1, QCT_OFF_VAL))
                    last_odd_reg[p] <= 1'b1;
                else if (wr_en && aw_addr_reg == ch_off(2*p, QCT_OFF_VAL))
                    last_odd_reg[p] <= 1'b0;
                if (ovf_evt)
                    active_odd_reg[p] <= last_odd_reg[p];
            end
        end
    end

    // Per-channel capture and compare
    for (genvar i = 0; i < QCT_NUM_CH; i++)
    begin : g_ch
        localparam bit ODD = (i % 2) == 1;
        logic             slave_linked;
        logic             is_ic;
        logic             rise;
        logic             fall;
        logic [CNT_W-1:0] cmp_val;
        logic             pin_nx;

        if (ODD)
        begin : g_odd
            assign slave_linked = ctrl_reg[i-1].ms_b;
            assign cmp_val      = val_reg[i];
        end
        else
        begin : g_even
            assign slave_linked = 1'b0;
            assign cmp_val      = (ctrl_reg[i].ms_b && active_odd_reg[i/2])
                                  ? val_reg[i+1] : val_reg[i];
        end

        assign is_oc[i] = (ctrl_reg[i].ms_a || ctrl_reg[i].ms_b) && !slave_linked;
        assign is_ic    = !ctrl_reg[i].ms_a && !ctrl_reg[i].ms_b && !slave_linked;
        assign rise     = chan_pin_in[i] && !pin_prev_reg[i];
        assign fall     = !chan_pin_in[i] && pin_prev_reg[i];
        assign cap_evt[i] = is_ic && ((ctrl_reg[i].els == QCT_ELS_RISE && rise)
                            || (ctrl_reg[i].els == QCT_ELS_FALL && fall)
                            || (ctrl_reg[i].els == QCT_ELS_EITHER && (rise || fall)));
        assign cmp_evt[i] = is_oc[i] && tick && !cnt_clr && cnt_next == cmp_val;
        assign chan_pin_oe[i]  = is_oc[i] && ctrl_reg[i].els != QCT_ELS_OFF;
        assign chan_pin_out[i] = pin_out_reg[i];
        assign channel_irq[i]  = chflag_reg[i] && ctrl_reg[i].irq_en;

        always_comb
        begin
            pin_nx = pin_out_reg[i] ^ (ovf_evt && ctrl_reg[i].tov);
            if (cmp_evt[i])
            begin
                case (ctrl_reg[i].els)
                    QCT_ACT_TOGGLE: pin_nx = !pin_nx;
                    QCT_ACT_CLEAR:  pin_nx = 1'b0;
                    QCT_ACT_SET:    pin_nx = 1'b1;
                    default:        pin_nx = pin_nx;
                endcase
            end
        end

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                ctrl_reg[i]     <= QCT_CTRL_RST;
                chflag_reg[i]   <= 1'b0;
                val_reg[i]      <= '0;
                pin_prev_reg[i] <= 1'b0;
                pin_out_reg[i]  <= 1'b0;
            end
            else
            begin
                pin_prev_reg[i] <= chan_pin_in[i];
                if (is_oc[i])
                    pin_out_reg[i] <= pin_nx;
                if (wr_en && aw_addr_reg == ch_off(i, 8'h00) && w_strb_reg[0])
                    ctrl_reg[i] <= w_data_reg[5:0];
                if (cap_evt[i] || cmp_evt[i])
                    chflag_reg[i] <= 1'b1;
                else if (wr_en && aw_addr_reg == ch_off(i, 8'h00) && w_strb_reg[0]
                         && w_data_reg[QCT_CSC_FLAG])
                    chflag_reg[i] <= 1'b0;
                if (cap_evt[i])
                    val_reg[i] <= cnt_reg;
                else if (wr_en && aw_addr_reg == ch_off(i, QCT_OFF_VAL))
                    val_reg[i] <= (w_data_reg[CNT_W-1:0] & wr_mask[CNT_W-1:0])
                                  | (val_reg[i] & ~wr_mask[CNT_W-1:0]);
            end
        end

        a_cap_latch: assert property (cap_evt[i] |=> val_reg[i] == $past(cnt_reg))
            else $error("capture did not latch count");
        a_ch_flag: assert property ((cap_evt[i] || cmp_evt[i]) |=> chflag_reg[i])
            else $error("channel flag not set");
        a_cmp_clear: assert property (cmp_evt[i] && ctrl_reg[i].els == QCT_ACT_CLEAR
            |=> !chan_pin_out[i])
            else $error("compare clear failed");
        a_tov_toggle: assert property (is_oc[i] && ovf_evt && ctrl_reg[i].tov && !cmp_evt[i]
            && !(wr_en && aw_addr_reg == ch_off(i, 8'h00))
            |=> chan_pin_out[i] != $past(chan_pin_out[i]))
            else $error("overflow toggle missing");
        a_no_tov: assert property (ovf_evt && !ctrl_reg[i].tov && !cmp_evt[i]
            |=> $stable(chan_pin_out[i]))
            else $error("pin moved on overflow without toggle");
    end

    a_cnt_wrap: assert property (tick && !cnt_clr && cnt_reg == limit |=> cnt_reg == '0)
        else $error("counter did not wrap to zero");
    a_cnt_step: assert property (tick && !cnt_clr && cnt_reg != limit
        |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("counter did not increment");
    a_ovf_flag: assert property (ovf_evt |=> overflow_flag_reg ##0 (overflow_irq == ovie_reg))
        else $error("overflow flag or request wrong");
    a_cnt_read: assert property (rd_take && s_axi_araddr == QCT_OFF_CNT
        |=> s_axi_rdata[CNT_W-1:0] == $past(cnt_reg) && s_axi_rvalid)
        else $error("counter read mismatch");
    a_presc_div1: assert property (presc_sel_reg == 3'h0 && !stop_reg |-> tick)
        else $error("undivided prescaler missed a tick");
    a_pair_free: assert property (ctrl_reg[0].ms_b |-> !chan_pin_oe[1] && !cmp_evt[1])
        else $error("linked channel 1 still active");
    a_buf_switch: assert property (ctrl_reg[2].ms_b && ovf_evt
        && !(wr_en && aw_addr_reg == ch_off(2, 8'h00))
        |=> active_odd_reg[1] == $past(last_odd_reg[1]))
        else $error("pair 2/3 handover wrong");

    c_pwm_cycle: cover property (ovf_evt ##[1:300] cmp_evt[0]);
    c_capture:   cover property (cap_evt[1]);
    c_buffered:  cover property (ctrl_reg[0].ms_b && active_odd_reg[0] && cmp_evt[0]);
    c_ext_clock: cover property (presc_sel_reg == QCT_PS_EXT && tick);
endmodule : qct_timer
`default_nettype wire

//--- testbench/qct_pin_env.sv
`default_nettype none
module qct_pin_env
(
    input  wire logic  aclk,
    output logic [3:0] pin_in,
    output logic       ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        pin_in  = 4'h0;
        ext_clk = 1'b0;
    end
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge aclk);
        pin_in[ch] <= lvl;
    endtask : set_pin
    // Clock idles low outside a burst
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            ext_clk <= 1'b1;
            repeat (2) @(posedge aclk);
            ext_clk <= 1'b0;
            @(posedge aclk);
        end
    endtask : ext_pulses
endmodule : qct_pin_env
`default_nettype wire

//--- testbench/test_quad_capture_compare_timer.sv
`default_nettype none
module test_quad_capture_compare_timer;
    import qct_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, external_clock_pin, overflow_irq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb, chan_pin_in, chan_pin_out, chan_pin_oe, channel_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rd_resp;
    int          num_errors = 0, comparisons = 0, cyc = 0, rd_cyc;
    qct_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_clock_pin,
        .chan_pin_in, .chan_pin_out, .chan_pin_oe, .overflow_irq, .channel_irq);
    qct_pin_env env (.aclk, .pin_in(chan_pin_in), .ext_clk(external_clock_pin));
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            wresp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            if (ta) rd_cyc = cyc;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wait_pin(input int ch, input logic lvl, output int t);
        do @(negedge aclk); while (chan_pin_out[ch] !== lvl);
        t = cyc;
    endtask : wait_pin
    task automatic t_regs();
        logic [31:0] a;
        int ta;
        rd(QCT_OFF_MOD);
        check("mod reset", rd_data, 32'h0000FFFF);
        rd(8'hFC);
        check("bad read", {30'h0, rd_resp}, {30'h0, QCT_RESP_SLVERR});
        wr(8'hFC, 32'h0);
        check("bad write", {30'h0, wresp}, {30'h0, QCT_RESP_SLVERR});
        rd(QCT_OFF_CNT);
        a = rd_data;
        ta = rd_cyc;
        rd(QCT_OFF_CNT);
        check("count step", rd_data - a, rd_cyc - ta);
        wr(QCT_OFF_TSC, 32'h00000007);
        rd(QCT_OFF_CNT);
        a = rd_data;
        env.ext_pulses(5);
        rd(QCT_OFF_CNT);
        check("ext count", rd_data - a, 32'h00000005);
        wr(QCT_OFF_TSC, 32'h00000003);
        rd(QCT_OFF_CNT);
        a = rd_data;
        repeat (13) @(posedge aclk);
        rd(QCT_OFF_CNT);
        check("div8 count", rd_data - a, 32'h00000002);
        $display("regs and counter done");
    endtask : t_regs
    task automatic t_capture();
        logic [31:0] c;
        wr(QCT_OFF_TSC, 32'h00000017);
        rd(QCT_OFF_CNT);
        c = rd_data;
        for (int e = 1; e < 4; e++)
        begin
            wr(8'h18, 32'h60 | e);
            env.set_pin(1, 1'b1);
            repeat (4) @(posedge aclk);
            check("rise irq", 32'(channel_irq[1]), 32'(e != 2));
            wr(8'h18, 32'h60 | e);
            env.set_pin(1, 1'b0);
            repeat (4) @(posedge aclk);
            check("fall irq", 32'(channel_irq[1]), 32'(e != 1));
            rd(8'h1C);
            check("capture", rd_data, c);
        end
        $display("capture done");
    endtask : t_capture
    task automatic t_pwm();
        int t0, t1, t2;
        logic hi;
        wr(QCT_OFF_TSC, 32'h000000B0);
        wr(QCT_OFF_MOD, 32'h000000FF);
        wr(8'h14, 32'h00000080);
        wr(8'h10, 32'h00000016);
        wr(QCT_OFF_TSC, 32'h00000140);
        wait_pin(0, 1'b1, t0);
        wait_pin(0, 1'b0, t1);
        wait_pin(0, 1'b1, t2);
        check("pwm width", t1 - t0, 32'd128);
        check("pwm period", t2 - t0, 32'd256);
        check("ovf irq", 32'(overflow_irq), 32'h1);
        check("ch0 irq", 32'(channel_irq[0]), 32'h0);
        wr(QCT_OFF_TSC, 32'h00000100);
        check("ovf masked", 32'(overflow_irq), 32'h0);
        wr(8'h10, 32'h00000006);
        wait_pin(0, 1'b0, t0);
        hi = 1'b0;
        repeat (300)
        begin
            @(negedge aclk);
            hi = hi | chan_pin_out[0];
        end
        check("no toggle", 32'(hi), 32'h0);
        $display("pwm done");
    endtask : t_pwm
    task automatic t_buffered();
        int t0, t1, t2;
        wr(QCT_OFF_TSC, 32'h00000130);
        wr(8'h10, 32'h0000001A);
        wr(8'h14, 32'h00000040);
        wr(8'h20, 32'h0000001A);
        wr(8'h24, 32'h00000020);
        wr(8'h18, 32'h00000006);
        wr(8'h28, 32'h00000006);
        wr(QCT_OFF_TSC, 32'h00000100);
        wait_pin(0, 1'b1, t0);
        wait_pin(2, 1'b0, t2);
        wait_pin(0, 1'b0, t1);
        check("pair0 width", t1 - t0, 32'h40);
        check("pair2 width", t2 - t0, 32'h20);
        check("ch1 oe", 32'(chan_pin_oe[1]), 32'h0);
        check("ch3 oe", 32'(chan_pin_oe[3]), 32'h0);
        wr(8'h1C, 32'h000000C0);
        wr(8'h2C, 32'h00000060);
        wait_pin(0, 1'b1, t0);
        wait_pin(2, 1'b0, t2);
        wait_pin(0, 1'b0, t1);
        check("pair1 width", t1 - t0, 32'hC0);
        check("pair3 width", t2 - t0, 32'h60);
        $display("buffered done");
    endtask : t_buffered
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_capture();
        t_pwm();
        t_buffered();
        tally_and_finish();
    end
endmodule : test_quad_capture_compare_timer
`default_nettype wire
